// ### rtl/csc_regs.sv
`include "csc_defs.svh"

module csc_regs #(
	parameter logic [7:0] PROCESSOR_IDENTIFIER   = 8'h5a, // arbitrary value
	parameter logic [7:0] SILICON_REVISION_FIELD = 8'h01, // arbitrary value
	parameter int         NUM_INT_LINES          = 16
) (
	input  wire logic                     clk,
	input  wire logic                     reset_n,
	input  wire logic                     ctl_wr_en,
	input  wire logic                     ctl_rd_en,
	input  wire logic                     ctl_sel,
	input  wire logic [31:0]              ctl_wdata,
	output logic      [31:0]              ctl_rdata,
	output logic                          ctl_rvalid,
	input  wire logic                     unit_saturate,
	input  wire logic                     unit_cond_true,
	input  wire logic                     interrupt_taken,
	input  wire logic [NUM_INT_LINES-1:0] int_request,
	output logic      [NUM_INT_LINES-1:0] int_masked,
	input  wire logic                     endian_strap,
	output logic                          endian_little,
	output logic                          saturation_flag,
	output logic                          global_interrupt_enable,
	output logic                          previous_interrupt_enable,
	output logic      [2:0]               program_cache_mode,
	output logic      [2:0]               data_cache_mode,
	output logic                          low_power_state_one,
	output logic                          low_power_state_two,
	output logic                          low_power_state_three,
	output logic                          l2_priority_crossbar,
	output logic      [2:0]               l2_split_mode,
	output logic      [6:0]               l2_cache_kbytes,
	output logic      [6:0]               l2_sram_kbytes,
	input  wire logic [1:0]               invalidate_done,
	output logic      [1:0]               invalidate_req
);
	if (NUM_INT_LINES < `CSC_FIRST_MASKABLE + 1 || NUM_INT_LINES > 32) begin : gen_bad
		$error("NUM_INT_LINES must lie between 5 and 32");
	end

	function automatic logic cache_mode_ok(input logic [2:0] m);
		cache_mode_ok = (m == `CSC_CACHE_ON_A) || (m == `CSC_CACHE_ON_B);
	endfunction

	function automatic logic l2_mode_ok(input logic [2:0] m);
		l2_mode_ok = (m <= `CSC_L2_THREE_WAY) || (m == `CSC_L2_FOUR_WAY);
	endfunction

	function automatic logic [6:0] l2_cache_kb(input logic [2:0] m);
		logic [2:0] ways;
		ways = (m == `CSC_L2_FOUR_WAY) ? 3'h4 : m;
		l2_cache_kb = 7'(ways) << `CSC_L2_WAY_SHIFT;
	endfunction

	logic                               cs_write;
	logic                               cc_write;
	logic [5:0]                         wr_power_code;
	logic                               saturation_clear;
	logic                               strap_meta;
	logic                               strap_sync;
	logic [1:0]                         strap_count;
	logic                               strap_taken;
	logic                               wake_enabled;
	logic                               wake_any;
	csc_pkg::csc_power_state_type       power_state;
	csc_pkg::csc_power_state_type       next_power_state;
	csc_inv_if                          inv ();

	assign cs_write         = ctl_wr_en && (ctl_sel == `CSC_SEL_CONTROL_STATUS);
	assign cc_write         = ctl_wr_en && (ctl_sel == `CSC_SEL_CACHE_CONFIG);
	assign wr_power_code    = ctl_wdata[`CSC_CS_POWER_HI:`CSC_CS_POWER_LO];
	assign saturation_clear = cs_write && !ctl_wdata[`CSC_CS_SATURATE]; // [R5]

	csc_saturation_flag u_saturation (
		.clk            (clk),
		.reset_n        (reset_n),
		.unit_saturate  (unit_saturate),
		.unit_cond_true (unit_cond_true),
		.clear          (saturation_clear),
		.flag           (saturation_flag)
	);

	// invalidate bits cannot be aborted by writing 0 while a sweep runs
	assign inv.start[`CSC_INV_PROG] = cc_write && ctl_wdata[`CSC_CC_INV_PROG]; // [R16]
	assign inv.start[`CSC_INV_DATA] = cc_write && ctl_wdata[`CSC_CC_INV_DATA]; // [R17]

	csc_inv_seq u_inv (
		.clk     (clk),
		.reset_n (reset_n),
		.inv     (inv.seq),
		.done    (invalidate_done),
		.req     (invalidate_req)
	);

	// endian strap: two-flop sync, then latched once the sync has settled
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			strap_meta <= 1'b0;
			strap_sync <= 1'b0;
		end else begin
			strap_meta <= endian_strap;
			strap_sync <= strap_meta;
		end
	end

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			strap_count   <= 2'h0;
			strap_taken   <= 1'b0;
			endian_little <= `CSC_RST_ENDIAN; // [R9]
		end else if (!strap_taken) begin
			if (strap_count == `CSC_STRAP_SETTLE) begin
				strap_taken   <= 1'b1;
				endian_little <= strap_sync; // [R9]
			end else begin
				strap_count <= strap_count + 2'h1;
			end
		end
	end

	// interrupt enables
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			global_interrupt_enable   <= 1'b0; // [R13]
			previous_interrupt_enable <= 1'b0; // [R12]
		end else begin
			if (cs_write) begin
				global_interrupt_enable <= ctl_wdata[`CSC_CS_INT_ENABLE];
			end
			if (interrupt_taken) begin
				previous_interrupt_enable <= global_interrupt_enable; // [R12]
			end else if (cs_write) begin
				previous_interrupt_enable <= ctl_wdata[`CSC_CS_PREV_ENABLE];
			end
		end
	end

	// lines 2 and 3 are reserved and never forwarded
	for (genvar g = 0; g < NUM_INT_LINES; g++) begin : gen_mask
		always_ff @(posedge clk) begin
			if (!reset_n) begin
				int_masked[g] <= 1'b0;
			end else if (g <= `CSC_NMI_LINE) begin
				int_masked[g] <= int_request[g]; // [R21]
			end else if (g < `CSC_FIRST_MASKABLE) begin
				int_masked[g] <= 1'b0;
			end else begin
				int_masked[g] <= int_request[g] & global_interrupt_enable; // [R13] [R21]
			end
		end
	end

	// cache modes: a reserved code is dropped and the field keeps its value
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			program_cache_mode <= `CSC_RST_CACHE_MODE;
			data_cache_mode    <= `CSC_RST_CACHE_MODE;
		end else if (cs_write) begin
			if (cache_mode_ok(ctl_wdata[`CSC_CS_PROG_MODE_HI:`CSC_CS_PROG_MODE_LO])) begin
				program_cache_mode <= ctl_wdata[`CSC_CS_PROG_MODE_HI:`CSC_CS_PROG_MODE_LO]; // [R10]
			end
			if (cache_mode_ok(ctl_wdata[`CSC_CS_DATA_MODE_HI:`CSC_CS_DATA_MODE_LO])) begin
				data_cache_mode <= ctl_wdata[`CSC_CS_DATA_MODE_HI:`CSC_CS_DATA_MODE_LO]; // [R11]
			end
		end
	end

	// power-down
	assign wake_enabled = int_request[`CSC_NMI_LINE] ||
		(global_interrupt_enable && |int_request[NUM_INT_LINES-1:`CSC_FIRST_MASKABLE]);
	assign wake_any     = |int_request;

	always_comb begin
		next_power_state = power_state;
		case (power_state)
			csc_pkg::power_run: begin
				if (cs_write) begin
					if (wr_power_code == `CSC_POWER_ONE_EN) begin
						next_power_state = csc_pkg::power_one_enabled; // [R3]
					end else if (wr_power_code == `CSC_POWER_ONE_ANY) begin
						next_power_state = csc_pkg::power_one_any; // [R3]
					end else if (wr_power_code == `CSC_POWER_TWO) begin
						next_power_state = csc_pkg::power_two; // [R4]
					end else if (wr_power_code == `CSC_POWER_THREE) begin
						next_power_state = csc_pkg::power_three; // [R4]
					end
				end
			end
			csc_pkg::power_one_enabled: begin
				if (wake_enabled) begin
					next_power_state = csc_pkg::power_run; // [R3]
				end
			end
			csc_pkg::power_one_any: begin
				if (wake_any) begin
					next_power_state = csc_pkg::power_run; // [R3]
				end
			end
			default: begin
				next_power_state = power_state; // [R4]
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			power_state           <= csc_pkg::power_run;
			low_power_state_one   <= 1'b0;
			low_power_state_two   <= 1'b0;
			low_power_state_three <= 1'b0;
		end else begin
			power_state           <= next_power_state;
			low_power_state_one   <= (next_power_state == csc_pkg::power_one_enabled) ||
				(next_power_state == csc_pkg::power_one_any);
			low_power_state_two   <= (next_power_state == csc_pkg::power_two);
			low_power_state_three <= (next_power_state == csc_pkg::power_three);
		end
	end

	// cache configuration
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			l2_priority_crossbar <= 1'b0; // [R14]
		end else if (cc_write) begin
			l2_priority_crossbar <= ctl_wdata[`CSC_CC_PRIORITY]; // [R14]
		end
	end

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			l2_split_mode   <= `CSC_RST_L2_MODE;
			l2_cache_kbytes <= 7'h00;
			l2_sram_kbytes  <= `CSC_L2_TOTAL_KB;
		end else if (cc_write && l2_mode_ok(ctl_wdata[`CSC_CC_L2_HI:`CSC_CC_L2_LO])) begin
			l2_split_mode   <= ctl_wdata[`CSC_CC_L2_HI:`CSC_CC_L2_LO]; // [R18]
			l2_cache_kbytes <= l2_cache_kb(ctl_wdata[`CSC_CC_L2_HI:`CSC_CC_L2_LO]); // [R19]
			l2_sram_kbytes  <= `CSC_L2_TOTAL_KB -
				l2_cache_kb(ctl_wdata[`CSC_CC_L2_HI:`CSC_CC_L2_LO]); // [R19]
		end
	end

	// read port: one-cycle latency, reserved fields read as zero
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			ctl_rdata  <= 32'h0000_0000;
			ctl_rvalid <= 1'b0;
		end else begin
			ctl_rvalid <= ctl_rd_en;
			if (ctl_rd_en && ctl_sel == `CSC_SEL_CONTROL_STATUS) begin
				ctl_rdata <= {PROCESSOR_IDENTIFIER, SILICON_REVISION_FIELD, // [R1]
					6'h00, saturation_flag, endian_little, // [R2] [R9]
					program_cache_mode, data_cache_mode,
					previous_interrupt_enable, global_interrupt_enable};
			end else if (ctl_rd_en) begin
				ctl_rdata <= {l2_priority_crossbar, 21'h00_0000, // [R15]
					inv.pending[`CSC_INV_PROG], inv.pending[`CSC_INV_DATA],
					5'h00, l2_split_mode}; // [R15]
			end
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (!reset_n);

	sequence cs_read;
		ctl_rd_en && ctl_sel == `CSC_SEL_CONTROL_STATUS;
	endsequence
	sequence cc_read;
		ctl_rd_en && ctl_sel == `CSC_SEL_CACHE_CONFIG;
	endsequence
	sequence enter_one_enabled;
		power_state == csc_pkg::power_run && cs_write && wr_power_code == `CSC_POWER_ONE_EN;
	endsequence

	chk_ident_readback: assert property (cs_read |=>
		ctl_rdata[31:16] == {PROCESSOR_IDENTIFIER, SILICON_REVISION_FIELD}) // [R1]
		else $error("identification value wrong");
	chk_power_reads_zero: assert property (cs_read |=> ctl_rdata[15:10] == 6'h00) // [R2]
		else $error("power-down field read nonzero");
	chk_pd_one_entry: assert property (enter_one_enabled |=>
		low_power_state_one && !low_power_state_two) // [R3]
		else $error("state one not entered");
	chk_pd_two_sticks: assert property (low_power_state_two |=> low_power_state_two) // [R4]
		else $error("state two left without reset");
	chk_enable_masks: assert property (!global_interrupt_enable |=>
		int_masked[NUM_INT_LINES-1:`CSC_FIRST_MASKABLE] == '0) // [R13]
		else $error("maskable line passed with enable off");
	chk_nmi_fixed: assert property (int_request[`CSC_NMI_LINE] |=>
		int_masked[`CSC_NMI_LINE]) // [R21]
		else $error("non-maskable line was gated");
	chk_prev_enable_copy: assert property (interrupt_taken |=>
		previous_interrupt_enable == $past(global_interrupt_enable)) // [R12]
		else $error("previous enable not saved");
	chk_prio_write: assert property (cc_write |=>
		l2_priority_crossbar == $past(ctl_wdata[`CSC_CC_PRIORITY])) // [R14]
		else $error("priority bit not written");
	chk_cc_reserved: assert property (cc_read |=>
		ctl_rdata[30:10] == 21'h00_0000 && ctl_rdata[7:3] == 5'h00) // [R15]
		else $error("reserved cache config bits nonzero");
	chk_l2_split: assert property (l2_cache_kbytes + l2_sram_kbytes == `CSC_L2_TOTAL_KB) // [R19]
		else $error("L2 split does not total 64K");
	chk_cache_mode_legal: assert property (cache_mode_ok(program_cache_mode) &&
		cache_mode_ok(data_cache_mode)) // [R10] [R11]
		else $error("reserved cache mode stored");
endmodule

// ### rtl/csc_defs.svh
// Functional notes
// [R1] top byte holds processor id, next byte silicon revision; read only
// [R2] power-down request field bits 15:10 always reads back as zero
// [R3] code 001001 enters state one (enabled wake), 010001 state one (any wake)
// [R4] codes 011010 and 011100 enter states two and three; reset exits only
// [R5] saturation flag bit 9 set by units, cleared only by control writes
// [R6] unit set beats control-write clear in the same cycle
// [R7] saturation flag shows set one full cycle after the saturating operation
// [R8] a saturating op whose condition is false leaves the flag alone
// [R9] bit 8 reads endian mode: 0 big, 1 little, little by default
// [R10] program cache mode bits 7:5, codes 000 and 010 enable, others reserved
// [R11] data cache mode bits 4:2, codes 000 and 010 enable, others reserved
// [R12] taking an interrupt copies global enable into previous enable; resets 0
// [R13] global enable bit 0 gates maskable interrupts; resets to 0
// [R14] cache config bit 31 picks L2 arbitration winner; resets to 0
// [R15] cache config bits 30:10 and 7:3 read only; writes ignored
// [R16] writing 1 to bit 9 invalidates all program cache lines
// [R17] writing 1 to bit 8 invalidates all data cache lines
// [R18] L2 mode bits 2:0 pick 0, 1, 2, 3 or 4 cache ways; others reserved
// [R19] every enabled cache way takes 16K from the 64K SRAM
// [R20] an invalidate bit returns to 0 once its invalidation completes
// [R21] global enable gates lines 4 to 15 only; lines 0 and 1 unmasked
`ifndef CSC_DEFS_SVH
`define CSC_DEFS_SVH

`define CSC_SEL_CONTROL_STATUS 1'h0
`define CSC_SEL_CACHE_CONFIG   1'h1

`define CSC_CS_POWER_HI     15
`define CSC_CS_POWER_LO     10
`define CSC_CS_SATURATE     9
`define CSC_CS_PROG_MODE_HI 7
`define CSC_CS_PROG_MODE_LO 5
`define CSC_CS_DATA_MODE_HI 4
`define CSC_CS_DATA_MODE_LO 2
`define CSC_CS_PREV_ENABLE  1
`define CSC_CS_INT_ENABLE   0

`define CSC_CC_PRIORITY  31
`define CSC_CC_RSV_HI_HI 30
`define CSC_CC_RSV_HI_LO 10
`define CSC_CC_INV_PROG  9
`define CSC_CC_INV_DATA  8
`define CSC_CC_RSV_LO_HI 7
`define CSC_CC_RSV_LO_LO 3
`define CSC_CC_L2_HI     2
`define CSC_CC_L2_LO     0

`define CSC_POWER_NONE     6'h00
`define CSC_POWER_ONE_EN   6'h09
`define CSC_POWER_ONE_ANY  6'h11
`define CSC_POWER_TWO      6'h1a
`define CSC_POWER_THREE    6'h1c

`define CSC_CACHE_ON_A     3'h0
`define CSC_CACHE_ON_B     3'h2
`define CSC_L2_ALL_SRAM    3'h0
`define CSC_L2_THREE_WAY   3'h3
`define CSC_L2_FOUR_WAY    3'h7
`define CSC_L2_TOTAL_KB    7'h40
`define CSC_L2_WAY_SHIFT   4

`define CSC_RST_CACHE_MODE 3'h0
`define CSC_RST_L2_MODE    3'h0
`define CSC_RST_ENDIAN     1'h1
`define CSC_NMI_LINE       1
`define CSC_FIRST_MASKABLE 4
`define CSC_STRAP_SETTLE   2'h2

`define CSC_INV_DATA       0
`define CSC_INV_PROG       1

`endif

// ### rtl/csc_pkg.sv
package csc_pkg;
	typedef enum logic [2:0] {
		power_run,
		power_one_enabled,
		power_one_any,
		power_two,
		power_three
	} csc_power_state_type;
endpackage

// ### rtl/csc_inv_if.sv
interface csc_inv_if;
	logic [1:0] start;
	logic [1:0] pending;
	modport regs (output start, input pending);
	modport seq (input start, output pending);
endinterface

// ### rtl/csc_sat_flag.sv
module csc_saturation_flag (
	input  wire logic clk,
	input  wire logic reset_n,
	input  wire logic unit_saturate,
	input  wire logic unit_cond_true,
	input  wire logic clear,
	output logic      flag
);
	logic pending;

	// one delay slot: the op is registered here before the flag moves
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			pending <= 1'b0;
		end else begin
			pending <= unit_saturate & unit_cond_true; // [R7] [R8]
		end
	end

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			flag <= 1'b0;
		end else if (pending) begin
			flag <= 1'b1; // [R5] [R6]
		end else if (clear) begin
			flag <= 1'b0; // [R5]
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (!reset_n);

	sequence saturate_event;
		unit_saturate && unit_cond_true;
	endsequence
	// a clear in the slot after the op may move the flag legally
	sequence false_cond_quiet;
		unit_saturate && !unit_cond_true ##1 !clear;
	endsequence

	chk_saturation_slot: assert property (saturate_event |-> ##2 flag) // [R7]
		else $error("saturation flag not set two edges after op");
	chk_set_wins: assert property (pending && clear |=> flag) // [R6]
		else $error("clear beat a unit set");
	chk_false_cond: assert property (false_cond_quiet |=> $stable(flag)) // [R8]
		else $error("false condition changed saturation flag");
	chk_set_cause: assert property ($rose(flag) |-> $past(pending)) // [R5]
		else $error("saturation flag set without a unit");
endmodule

// ### rtl/csc_inv_seq.sv
module csc_inv_seq (
	input  wire logic       clk,
	input  wire logic       reset_n,
	csc_inv_if.seq          inv,
	input  wire logic [1:0] done,
	output logic      [1:0] req
);
	assign inv.pending = req;

	// one tracker per cache; a new start in the done cycle restarts the sweep
	for (genvar g = 0; g < 2; g++) begin : gen_inv
		always_ff @(posedge clk) begin
			if (!reset_n) begin
				req[g] <= 1'b0;
			end else if (inv.start[g]) begin
				req[g] <= 1'b1; // [R16] [R17]
			end else if (done[g]) begin
				req[g] <= 1'b0; // [R20]
			end
		end

		chk_inv_request: assert property (@(posedge clk) disable iff (!reset_n)
			inv.start[g] |=> req[g]) // [R16] [R17]
			else $error("invalidate start did not raise request");
		chk_inv_self_clear: assert property (@(posedge clk) disable iff (!reset_n)
			req[g] && done[g] && !inv.start[g] |=> !req[g]) // [R20]
			else $error("invalidate bit did not return to zero");
	end
endmodule

// ### sim/csc_cache_model.sv
module csc_cache_model (
	input  wire logic       clk,
	input  wire logic       reset_n,
	input  wire logic [1:0] req,
	input  wire logic [3:0] delay,
	output logic      [1:0] done
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [3:0] cnt [2];

	// one sweep per request; done is a single pulse, then a req still high starts another sweep
	for (genvar i = 0; i < 2; i++) begin : g_way
		always_ff @(posedge clk) begin
			if (!reset_n || !req[i] || done[i]) begin
				cnt[i]  <= 4'h0;
				done[i] <= 1'b0;
			end else if (cnt[i] == delay) begin
				done[i] <= 1'b1;
			end else begin
				cnt[i] <= cnt[i] + 4'h1;
			end
		end
	end
endmodule

// ### sim/test_csc_regs.sv
module test_csc_regs;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [7:0] PID = 8'h3c; // arbitrary value
	localparam logic [7:0] REV = 8'h07; // arbitrary value
	logic        clk = 1'b0;
	logic        reset_n = 1'b0;
	logic        ctl_wr_en = 1'b0;
	logic        ctl_rd_en = 1'b0;
	logic        ctl_sel = 1'b0;
	logic [31:0] ctl_wdata = 32'h0;
	logic [31:0] ctl_rdata;
	logic        ctl_rvalid;
	logic        endian_strap = 1'b1;
	logic        unit_saturate = 1'b0;
	logic        unit_cond_true = 1'b0;
	logic        interrupt_taken = 1'b0;
	logic [15:0] int_request = 16'h0;
	logic [15:0] int_masked;
	logic        endian_little, saturation_flag, int_en, prev_en;
	logic [2:0]  prog_mode, data_mode, l2_mode;
	logic        lp_one, lp_two, lp_three, prio;
	logic [6:0]  cache_kb, sram_kb;
	logic [1:0]  inv_done, inv_req;
	logic [3:0]  inv_delay = 4'h5;
	logic [31:0] rd;
	int          miscompares = 0;
	int          tests_run = 0;

	always #5 clk = ~clk;

	csc_regs #(.PROCESSOR_IDENTIFIER(PID), .SILICON_REVISION_FIELD(REV)) i_dut (
		.clk(clk), .reset_n(reset_n), .ctl_wr_en(ctl_wr_en), .ctl_rd_en(ctl_rd_en),
		.ctl_sel(ctl_sel), .ctl_wdata(ctl_wdata), .ctl_rdata(ctl_rdata),
		.ctl_rvalid(ctl_rvalid), .unit_saturate(unit_saturate),
		.unit_cond_true(unit_cond_true), .interrupt_taken(interrupt_taken),
		.int_request(int_request), .int_masked(int_masked), .endian_strap(endian_strap),
		.endian_little(endian_little), .saturation_flag(saturation_flag),
		.global_interrupt_enable(int_en), .previous_interrupt_enable(prev_en),
		.program_cache_mode(prog_mode), .data_cache_mode(data_mode),
		.low_power_state_one(lp_one),
		.low_power_state_two(lp_two), .low_power_state_three(lp_three),
		.l2_priority_crossbar(prio), .l2_split_mode(l2_mode), .l2_cache_kbytes(cache_kb),
		.l2_sram_kbytes(sram_kb), .invalidate_done(inv_done), .invalidate_req(inv_req));

	csc_cache_model i_cache (.clk(clk), .reset_n(reset_n), .req(inv_req),
		.delay(inv_delay), .done(inv_done));

	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			miscompares++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	task automatic do_reset();
		@(posedge clk) #1 reset_n = 1'b0;
		cyc(8);
		reset_n = 1'b1;
		cyc(5);
	endtask

	task automatic wr(input logic sel, input logic [31:0] d);
		@(posedge clk) #1 ctl_wr_en = 1'b1;
		ctl_sel = sel;
		ctl_wdata = d;
		@(posedge clk) #1 ctl_wr_en = 1'b0;
	endtask

	task automatic rdreg(input logic sel, output logic [31:0] d);
		@(posedge clk) #1 ctl_rd_en = 1'b1;
		ctl_sel = sel;
		@(posedge clk) #1 ctl_rd_en = 1'b0;
		check(32'(ctl_rvalid), 32'h1);
		d = ctl_rdata;
	endtask

	task automatic results();
		$display("compares %0d mismatches %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	initial begin
		#200000;
		miscompares++;
		results();
	end

	initial begin
		do_reset();
		rdreg(1'b0, rd);
		check(rd, {PID, REV, 16'h0100});
		rdreg(1'b1, rd);
		check(rd, 32'h0);
		check(32'(sram_kb), 32'd64);
		$display("test reset_values done");

		wr(1'b0, 32'h0000_0048);
		wr(1'b0, 32'hffff_fc2c);
		rdreg(1'b0, rd);
		check(rd, {PID, REV, 16'h0148});
		check({29'h0, prog_mode}, 32'h2);
		check({29'h0, data_mode}, 32'h2);
		check(32'(endian_little), 32'h1);
		$display("test cpu_fields done");

		unit_cond_true = 1'b1;
		@(posedge clk) #1 unit_saturate = 1'b1;
		@(posedge clk) #1 unit_saturate = 1'b0;
		check(32'(saturation_flag), 32'h0);
		cyc(1);
		check(32'(saturation_flag), 32'h1);
		wr(1'b0, 32'h0);
		check(32'(saturation_flag), 32'h0);
		unit_cond_true = 1'b1;
		@(posedge clk) #1 unit_saturate = 1'b1;
		@(posedge clk) #1 unit_saturate = 1'b0;
		ctl_wr_en = 1'b1;
		ctl_sel = 1'b0;
		ctl_wdata = 32'h0;
		@(posedge clk) #1 ctl_wr_en = 1'b0;
		check(32'(saturation_flag), 32'h1);
		wr(1'b0, 32'h0000_0200);
		check(32'(saturation_flag), 32'h1);
		wr(1'b0, 32'h0);
		check(32'(saturation_flag), 32'h0);
		unit_cond_true = 1'b0;
		@(posedge clk) #1 unit_saturate = 1'b1;
		@(posedge clk) #1 unit_saturate = 1'b0;
		cyc(3);
		check(32'(saturation_flag), 32'h0);
		$display("test saturation done");

		int_request = 16'hffff;
		wr(1'b0, 32'h1);
		cyc(2);
		check({16'h0, int_masked}, 32'h0000_fff3);
		@(posedge clk) #1 interrupt_taken = 1'b1;
		@(posedge clk) #1 interrupt_taken = 1'b0;
		check(32'(prev_en), 32'h1);
		rdreg(1'b0, rd);
		check(rd, {PID, REV, 16'h0103});
		wr(1'b0, 32'h0000_0002);
		cyc(2);
		check({16'h0, int_masked}, 32'h0000_0003);
		@(posedge clk) #1 interrupt_taken = 1'b1;
		@(posedge clk) #1 interrupt_taken = 1'b0;
		check(32'(prev_en), 32'h0);
		int_request = 16'h0;
		$display("test interrupt_enable done");

		wr(1'b0, {16'h0, 6'h09, 10'h001});
		check(32'(lp_one), 32'h1);
		wr(1'b0, {16'h0, 6'h1a, 10'h001});
		check({29'h0, lp_one, lp_two, lp_three}, 32'h4);
		@(posedge clk) #1 int_request = 16'h0010;
		@(posedge clk) #1 int_request = 16'h0;
		check(32'(lp_one), 32'h0);
		wr(1'b0, {16'h0, 6'h09, 10'h000});
		@(posedge clk) #1 int_request = 16'h0020;
		cyc(3);
		check(32'(lp_one), 32'h1);
		int_request = 16'h0002;
		@(posedge clk) #1 int_request = 16'h0;
		check(32'(lp_one), 32'h0);
		wr(1'b0, {16'h0, 6'h11, 10'h000});
		check(32'(lp_one), 32'h1);
		@(posedge clk) #1 int_request = 16'h0020;
		@(posedge clk) #1 int_request = 16'h0;
		check(32'(lp_one), 32'h0);
		wr(1'b0, {16'h0, 6'h15, 10'h000});
		check({29'h0, lp_one, lp_two, lp_three}, 32'h0);
		wr(1'b0, {16'h0, 6'h1a, 10'h000});
		int_request = 16'hffff;
		cyc(4);
		check({29'h0, lp_one, lp_two, lp_three}, 32'h2);
		int_request = 16'h0;
		do_reset();
		check({29'h0, lp_one, lp_two, lp_three}, 32'h0);
		wr(1'b0, {16'h0, 6'h1c, 10'h000});
		cyc(4);
		check({29'h0, lp_one, lp_two, lp_three}, 32'h1);
		endian_strap = 1'b0;
		do_reset();
		check(32'(lp_three), 32'h0);
		check(32'(endian_little), 32'h0);
		rdreg(1'b0, rd);
		check(rd, {PID, REV, 16'h0000});
		$display("test power_down done");

		wr(1'b1, 32'hffff_ffff);
		check({30'h0, inv_req}, 32'h3);
		check(32'(prio), 32'h1);
		rdreg(1'b1, rd);
		check(rd, 32'h8000_0307);
		for (int i = 0; i < 50 && inv_req !== 2'b00; i++) cyc(1);
		check({30'h0, inv_req}, 32'h0);
		rdreg(1'b1, rd);
		check(rd, 32'h8000_0007);
		for (int k = 0; k < 5; k++) begin
			logic [2:0] code;
			int         ways;
			code = (k == 4) ? 3'h7 : 3'(k);
			ways = (k == 4) ? 4 : k;
			wr(1'b1, {29'h0, code});
			check({29'h0, l2_mode}, {29'h0, code});
			check(32'(cache_kb), 32'(16 * ways));
			check(32'(sram_kb), 32'(64 - 16 * ways));
		end
		wr(1'b1, 32'h0000_0004);
		check({29'h0, l2_mode}, 32'h7);
		check(32'(prio), 32'h0);
		wr(1'b1, 32'h0000_0200);
		check({30'h0, inv_req}, 32'h2);
		for (int i = 0; i < 50 && inv_req !== 2'b00; i++) cyc(1);
		check({30'h0, inv_req}, 32'h0);
		$display("test cache_config done");
		results();
	end
endmodule
